//--- design/cdcsc_top.sv
`timescale 1ns/1ns
`include "cdcsc_consts.svh"
module cdcsc_top
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  conv_done,
  input  wire cdcsc_pkg::cdcsc_chan_t conv_chan,
  input  wire logic                  conv_cap_ch,
  input  wire logic [23:0]           conv_raw,
  input  wire logic                  offs_cal_mode,
  input  wire logic                  offs_wr,
  input  wire logic [15:0]           offs_wdata,
  input  wire logic                  gain_wr,
  input  wire logic [15:0]           gain_wdata,
  input  wire logic [15:0]           otp_gain,
  input  wire logic                  vref_ext_sel,
  output logic      [15:0]           offs_coef,
  output logic      [15:0]           gain_coef,
  output logic      [23:0]           result,
  output logic                       result_valid,
  output logic                       result_cap_ch,
  output logic                       vref_ext_en,
  output logic                       vdd_div_en,
  output logic      [2:0]            vdd_div_ratio
);
  logic [23:0] scaled;
  logic        load_otp;
  logic        cap_conv;
  logic [15:0] cal_offs;

  function automatic logic chan_is
  (
    input cdcsc_pkg::cdcsc_chan_t c,
    input cdcsc_pkg::cdcsc_chan_t want
  );
    return c == want;
  endfunction

  assign cap_conv = conv_done && chan_is(conv_chan, cdcsc_pkg::CDCSC_CH_CAP);
  // new zero point: offs such that raw - 2*(offs-default) == mid
  assign cal_offs = 16'(({8'h00, conv_raw} - {8'h00, `CDCSC_MIDCODE}) >> `CDCSC_OFFS_SHIFT)
                    + `CDCSC_OFFS_DEFAULT;
  cdcsc_scale u_scale
  (
    .raw    (conv_raw),
    .offs   (offs_coef),
    .gain   (gain_coef),
    .scaled (scaled)
  );

  // single coefficient for both channels; default, never a factory value
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      offs_coef <= `CDCSC_OFFS_DEFAULT;
    else if (offs_cal_mode && cap_conv)
      offs_coef <= cal_offs;
    else if (offs_wr)
      offs_coef <= offs_wdata;
  end

  // otp copied on first edge after release; reset branch may only load constants
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      load_otp <= 1'b1;
    else
      load_otp <= 1'b0;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gain_coef <= `CDCSC_GAIN_ONE;
    else if (load_otp)
      gain_coef <= otp_gain;
    else if (gain_wr)
      gain_coef <= gain_wdata;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result        <= 24'h000000;
      result_valid  <= 1'b0;
      result_cap_ch <= 1'b0;
    end
    else
    begin
      result_valid <= conv_done;
      if (conv_done)
      begin
        result_cap_ch <= conv_cap_ch;
        // temperature raw arrives factory-scaled to code/2048 - 4096
        unique case (conv_chan)
          cdcsc_pkg::CDCSC_CH_CAP:  result <= scaled;
          cdcsc_pkg::CDCSC_CH_TEMP: result <= conv_raw;
          cdcsc_pkg::CDCSC_CH_VOLT: result <= conv_raw;
          cdcsc_pkg::CDCSC_CH_VDD:  result <= conv_raw;
        endcase
      end
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vref_ext_en   <= 1'b0;
      vdd_div_en    <= 1'b0;
      vdd_div_ratio <= `CDCSC_VDD_DIV;
    end
    else
    begin
      vref_ext_en   <= vref_ext_sel;
      vdd_div_en    <= chan_is(conv_chan, cdcsc_pkg::CDCSC_CH_VDD);
      vdd_div_ratio <= `CDCSC_VDD_DIV;
    end
  end

  chk_offs_reset: assert property (@(posedge clk)
    $fell(rst) |-> offs_coef == `CDCSC_OFFS_DEFAULT)
    else $error("offset not default after reset");

  chk_gain_otp: assert property (@(posedge clk) disable iff (rst)
    load_otp |=> gain_coef == $past(otp_gain))
    else $error("otp gain not loaded");

  chk_cal_mid: assert property (@(posedge clk) disable iff (rst)
    offs_cal_mode && cap_conv && !offs_wr |=> offs_coef == $past(cal_offs))
    else $error("calibration did not capture");

  chk_offs_write: assert property (@(posedge clk) disable iff (rst)
    offs_wr && !(offs_cal_mode && cap_conv) |=> offs_coef == $past(offs_wdata))
    else $error("offset write lost");

  chk_cap_scaled: assert property (@(posedge clk) disable iff (rst)
    cap_conv |=> result_valid && result == $past(scaled))
    else $error("cap result not scaled");

  chk_temp_pass: assert property (@(posedge clk) disable iff (rst)
    conv_done && conv_chan == cdcsc_pkg::CDCSC_CH_TEMP |=> result == $past(conv_raw))
    else $error("temperature result altered");

  chk_vref_sel: assert property (@(posedge clk) disable iff (rst)
    vref_ext_sel |=> vref_ext_en)
    else $error("external reference not selected");

  chk_vdd_div: assert property (@(posedge clk) disable iff (rst)
    conv_chan == cdcsc_pkg::CDCSC_CH_VDD |=> vdd_div_en && vdd_div_ratio == 3'h6)
    else $error("supply divider wrong");

  chk_offs_hold: assert property (@(posedge clk) disable iff (rst)
    !(offs_cal_mode && cap_conv) && !offs_wr |=> $stable(offs_coef))
    else $error("offset changed without cause");

  chk_cal_wins: assert property (@(posedge clk) disable iff (rst)
    offs_cal_mode && cap_conv && offs_wr |=> offs_coef == $past(cal_offs))
    else $error("write beat calibration");

  chk_gain_write: assert property (@(posedge clk) disable iff (rst)
    !load_otp && gain_wr |=> gain_coef == $past(gain_wdata))
    else $error("gain write lost");

  chk_gain_hold: assert property (@(posedge clk) disable iff (rst)
    !load_otp && !gain_wr |=> $stable(gain_coef))
    else $error("gain changed without cause");

  chk_load_once: assert property (@(posedge clk) disable iff (rst)
    load_otp |=> !load_otp)
    else $error("otp load repeated");

  chk_gain_reset: assert property (@(posedge clk)
    $fell(rst) |-> gain_coef == `CDCSC_GAIN_ONE)
    else $error("gain not at reset value");

  chk_valid_set: assert property (@(posedge clk) disable iff (rst)
    conv_done |=> result_valid)
    else $error("result valid missing");

  chk_valid_clear: assert property (@(posedge clk) disable iff (rst)
    !conv_done |=> !result_valid)
    else $error("result valid stuck");

  chk_result_hold: assert property (@(posedge clk) disable iff (rst)
    !conv_done |=> $stable(result))
    else $error("result changed without conversion");

  chk_zero_pass: assert property (@(posedge clk) disable iff (rst)
    cap_conv && offs_coef == `CDCSC_OFFS_DEFAULT && gain_coef == `CDCSC_GAIN_ONE
    |=> result == $past(conv_raw))
    else $error("hidden offset applied");

  chk_cap_lane: assert property (@(posedge clk) disable iff (rst)
    conv_done |=> result_cap_ch == $past(conv_cap_ch))
    else $error("cap channel flag wrong");

  chk_lane_hold: assert property (@(posedge clk) disable iff (rst)
    !conv_done |=> $stable(result_cap_ch))
    else $error("cap channel flag moved");

  chk_volt_pass: assert property (@(posedge clk) disable iff (rst)
    conv_done && conv_chan == cdcsc_pkg::CDCSC_CH_VOLT |=> result == $past(conv_raw))
    else $error("voltage result altered");

  chk_vref_int: assert property (@(posedge clk) disable iff (rst)
    !vref_ext_sel |=> !vref_ext_en)
    else $error("internal reference not selected");

  chk_vref_reset: assert property (@(posedge clk)
    $fell(rst) |-> !vref_ext_en && !result_valid)
    else $error("outputs not cleared by reset");

  chk_vdd_pass: assert property (@(posedge clk) disable iff (rst)
    conv_done && conv_chan == cdcsc_pkg::CDCSC_CH_VDD |=> result == $past(conv_raw))
    else $error("supply result altered");

  chk_vdd_off: assert property (@(posedge clk) disable iff (rst)
    conv_chan != cdcsc_pkg::CDCSC_CH_VDD |=> !vdd_div_en)
    else $error("supply divider left on");

  chk_ratio_const: assert property (@(posedge clk) disable iff (rst)
    vdd_div_ratio == `CDCSC_VDD_DIV)
    else $error("supply divide ratio wrong");
endmodule

//--- include/cdcsc_consts.svh
// Operation
// - offset calibration mode makes present zero-scale input yield midpoint code 0x800000; code reaches it only with gain_coef at CDCSC_GAIN_ONE
// - host may write offset coefficient; one step is 31.25 aF
// - power-on and reset restore offset coefficient to its default
// - one offset coefficient shared by both capacitive channels
// - no factory capacitive offset is applied
// - temperature code scaled so degC equals code/2048 minus 4096
// - voltage channel selects internal 1.17 V or external reference
// - supply monitor conversion divides supply by six first
// - factory gain reloaded from OTP at power-up and reset
`ifndef CDCSC_CONSTS_SVH
`define CDCSC_CONSTS_SVH
`define CDCSC_MIDCODE      24'h800000
`define CDCSC_OFFS_DEFAULT 16'h8000
`define CDCSC_OFFS_SHIFT   1
`define CDCSC_GAIN_ONE     16'h0000
`define CDCSC_GAIN_SHIFT   16
`define CDCSC_TEMP_OFFSET  24'h800000
`define CDCSC_VDD_DIV      3'h6
`endif

//--- include/cdcsc_pkg.sv
package cdcsc_pkg;
  typedef enum logic [1:0]
  {
    CDCSC_CH_CAP  = 2'b00,
    CDCSC_CH_TEMP = 2'b01,
    CDCSC_CH_VOLT = 2'b10,
    CDCSC_CH_VDD  = 2'b11
  } cdcsc_chan_t;
endpackage

//--- design/cdcsc_scale.sv
`timescale 1ns/1ns
`include "cdcsc_consts.svh"
module cdcsc_scale
(
  input  wire logic [23:0] raw,
  input  wire logic [15:0] offs,
  input  wire logic [15:0] gain,
  output logic      [23:0] scaled
);
  logic signed [25:0] centred;
  logic signed [43:0] prod;
  logic signed [43:0] adj;
  always_comb
  begin
    // offset code is 2^15 midpoint; one step equals two result lsbs
    centred = $signed({2'b00, raw}) - $signed({9'h000, offs, 1'b0})
              + $signed({10'h000, `CDCSC_OFFS_DEFAULT}) * 26'sd2;
    prod = centred * $signed({1'b0, gain});
    adj = $signed({{18{centred[25]}}, centred}) + (prod >>> `CDCSC_GAIN_SHIFT);
    if (adj < 0)
      scaled = 24'h000000;
    else if (adj > 44'sh0000_0ff_ffff)
      scaled = 24'hffffff;
    else
      scaled = adj[23:0];
  end
endmodule

//--- bench/cdcsc_host.sv
`timescale 1ns/1ns
module cdcsc_host
(
  input  wire logic        clk,
  output logic             offs_wr,
  output logic [15:0]      offs_wdata,
  output logic             gain_wr,
  output logic [15:0]      gain_wdata
);
  initial {offs_wr, gain_wr, offs_wdata, gain_wdata} = '0;
  // host writes the given value to the offset or gain coefficient, strobe held one cycle
  task wr(input logic g, input logic [15:0] v);
    @(negedge clk);
    if (g) {gain_wr, gain_wdata} = {1'b1, v};
    else {offs_wr, offs_wdata} = {1'b1, v};
    @(negedge clk);
    {offs_wr, gain_wr} = 2'b00;
    // released data lines must not keep looking valid
    {offs_wdata, gain_wdata} = {~offs_wdata, ~gain_wdata};
  endtask
endmodule

//--- bench/cdc_offset_cal_scaling_tb.sv
`timescale 1ns/1ns
`include "cdcsc_consts.svh"
module cdc_offset_cal_scaling_tb;
  logic                   clk = 0, rst = 1, done = 0, cap_ch = 0, cal = 0, vsel = 0;
  cdcsc_pkg::cdcsc_chan_t chan = cdcsc_pkg::CDCSC_CH_CAP;
  logic [23:0]            raw = '0, result, r;
  logic [15:0]            otp = '0, ow, gw, oc, gc, o, g;
  logic                   owr, gwr, rv, rc, ven, vden;
  logic [2:0]             ratio;
  logic [25:0]            q[$], e;
  int                     fails = 0, n_compared = 0;
  always #5 clk = ~clk;
  cdcsc_host host (.clk(clk), .offs_wr(owr), .offs_wdata(ow), .gain_wr(gwr), .gain_wdata(gw));
  cdcsc_top uut (.clk(clk), .rst(rst), .conv_done(done), .conv_chan(chan), .conv_cap_ch(cap_ch),
    .conv_raw(raw), .offs_cal_mode(cal), .offs_wr(owr), .offs_wdata(ow), .gain_wr(gwr),
    .gain_wdata(gw), .otp_gain(otp), .vref_ext_sel(vsel), .offs_coef(oc), .gain_coef(gc),
    .result(result), .result_valid(rv), .result_cap_ch(rc), .vref_ext_en(ven),
    .vdd_div_en(vden), .vdd_div_ratio(ratio));
  task chk(input logic [23:0] s, x);
    n_compared++;
    if (s !== x)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, s, x);
    end
  endtask
  function logic [23:0] sc(input logic [23:0] a, input logic [15:0] oo, gg);
    longint c;
    c = longint'(a) - 2 * (longint'(oo) - 32768);
    c = c + ((c * longint'(gg)) >>> 16);
    return c < 0 ? 24'h0 : c > 16777215 ? 24'hffffff : c[23:0];
  endfunction
  task conv(input cdcsc_pkg::cdcsc_chan_t c, input logic [23:0] a, x, input logic s);
    @(negedge clk);
    chan = c;
    {raw, done, cap_ch} = {a, 1'b1, 1'($urandom)};
    q.push_back({s, cap_ch, x});
    @(negedge clk);
    {done, raw} = {1'b0, ~a};
  endtask
  task close_out;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk)
    if (rv === 1'b1)
    begin
      e = q.size() ? q.pop_front() : 26'h0;
      if (!e[25]) chk(result, e[23:0]);
      chk(24'(rc), 24'(e[24]));
    end
  initial
  begin
    void'($urandom(74));
    otp = 16'($urandom);
    repeat (2) @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk(24'(oc), 24'(`CDCSC_OFFS_DEFAULT));
    chk(24'(gc), 24'(otp));
    chk(24'(ratio), 24'(`CDCSC_VDD_DIV));
    host.wr(1, 16'h0);
    r = 24'($urandom);
    conv(cdcsc_pkg::CDCSC_CH_CAP, r, r, 0);
    repeat (6)
    begin
      {o, g, r} = {16'($urandom), 16'($urandom), 24'($urandom)};
      host.wr(0, o);
      host.wr(1, g);
      conv(cdcsc_pkg::CDCSC_CH_CAP, r, sc(r, o, g), 0);
      conv(cdcsc_pkg::CDCSC_CH_CAP, ~r, sc(~r, o, g), 0);
    end
    for (int k = 1; k < 4; k++)
      conv(cdcsc_pkg::cdcsc_chan_t'(k), r, r, 0);
    vsel = 1;
    repeat (2) @(negedge clk);
    chk(24'(ven), 24'h1);
    host.wr(1, 16'h0);
    cal = 1;
    r = 24'h800000 + 24'(2 * ($urandom % 1000));
    conv(cdcsc_pkg::CDCSC_CH_CAP, r, 24'h0, 1);
    cal = 0;
    chk(24'(oc), 24'(16'h8000 + 16'((r - 24'h800000) >> 1)));
    conv(cdcsc_pkg::CDCSC_CH_CAP, r, `CDCSC_MIDCODE, 0);
    repeat (2) @(negedge clk);
    rst = 1;
    @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk(24'(oc), 24'(`CDCSC_OFFS_DEFAULT));
    chk(24'(gc), 24'(otp));
    for (int i = 0; i < 20 && q.size() > 0; i++)
      @(negedge clk);
    if (q.size() > 0) fails++;
    close_out;
  end
endmodule
